/* shared/lvdc_consts.svh */
// offsets, field positions, reset values and timing counts of the
// low-voltage detect control block; included by the logic and the bench
`ifndef LVDC_CONSTS_SVH
`define LVDC_CONSTS_SVH
// register byte offsets
`define LVDC_CTRL_OFS      12'h000
`define LVDC_STAT_OFS      12'h004
`define LVDC_IEN_OFS       12'h008
`define LVDC_ICLR_OFS      12'h00c
`define LVDC_MASK_OFS      12'h010
`define LVDC_BITSET_OFS    12'h014
`define LVDC_BITCLR_OFS    12'h018
// control register fields
`define LVDC_CMP_BIT       0
`define LVDC_MODE_BIT      1
`define LVDC_SEL_BIT       2
`define LVDC_ON_BIT        7
// status / enable / clear fields
`define LVDC_ST_REQ_BIT    0
`define LVDC_ST_RDY_BIT    1
`define LVDC_ST_W          2
// reset values
`define LVDC_CTRL_RST      8'h00
`define LVDC_MASK_RST      1'b1
`define LVDC_IEN_RST       2'h0
// settle time after enable, in ns, and the clock period in ns
`define LVDC_SETTLE_NS     210000
`define LVDC_CLK_NS        10
`endif

/* shared/lvdc_pkg.sv */
// types of the low-voltage detect control block
// assumes lvdc_consts.svh sits on the include path
package lvdc_pkg;
   // detector sequencing states
   typedef enum logic [1:0] {
      LVDC_OFF,
      LVDC_SETTLE,
      LVDC_READY
   } lvdc_state_t;
   typedef logic [1:0] lvdc_resp_t;
endpackage

/* logic/lvdc_core.sv */
// low-voltage detect control: control register, settle timer, level
// flag and interrupt request, reached over an axi4-lite slave
// assumes aclk at 100 MHz and the comparator output arriving async
// assumes an axi4-lite master with one write and one read in flight
// assumes the comparator pins change slowly next to the clock
//
// Operation
// - select bit 2 makes the detector compare the external input
// - mode bit 1 at 0 (default) makes detection raise a request
// - on bit 7 enables the detector; at 0 it stays idle
// - bit 0 reports the input below detection level
// - on bit cleared alone, other control bits undisturbed
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "lvdc_consts.svh"

module lvdc_core #(
   parameter int SETTLE_CYCLES = `LVDC_SETTLE_NS / `LVDC_CLK_NS
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output lvdc_pkg::lvdc_resp_t       s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output lvdc_pkg::lvdc_resp_t       s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  supply_below_level,
   input  wire logic                  ext_below_level,
   output logic                       detector_enable,
   output logic                       ext_input_route,
   output logic                       lowvolt_reset_req,
   output logic                       irq
);
   import lvdc_pkg::*;

   // ==========================================================
   // elaboration checks
   // the settle counter needs at least one cycle to count through
   if (SETTLE_CYCLES < 1) begin : g_bad_settle
      $error("SETTLE_CYCLES must be at least 1");
   end

   // counter width follows the parameter, a longer wait only widens it
   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

   // ==========================================================
   // registers
   // software-visible state
   logic [7:0]              ctrl_r;      // on, select, mode bits
   logic                    mask_r;      // lowvolt_irq_mask
   logic [`LVDC_ST_W-1:0]   stat_r;      // sticky events
   logic [`LVDC_ST_W-1:0]   ien_r;

   // settle sequencer and comparator history
   lvdc_state_t             state_r;
   logic [CNT_W-1:0]        cnt_r;
   logic [1:0]              sup_sync_r;
   logic [1:0]              ext_sync_r;
   logic                    cmp_prev_r;

   // write channel parts held until the other part arrives
   logic                    aw_held_r;
   logic [11:0]             aw_addr_r;
   logic                    w_held_r;
   logic [31:0]             w_data_r;
   logic                    w_lane0_r;

   // ==========================================================
   // comparator input synchronisers
   // the first flop may settle late; nothing but the second reads it
   // reset to the idle level so no false edge follows reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sup_sync_r <= 2'h0;
         ext_sync_r <= 2'h0;
      end else begin
         sup_sync_r <= {sup_sync_r[0], supply_below_level};
         ext_sync_r <= {ext_sync_r[0], ext_below_level};
      end
   end

   // ==========================================================
   // detector view of the selected level
   wire det_on    = ctrl_r[`LVDC_ON_BIT];
   wire sel_ext   = ctrl_r[`LVDC_SEL_BIT];
   wire mode_rst  = ctrl_r[`LVDC_MODE_BIT];
   // detector output forced low while off, so nothing fires idle
   wire cmp_sel   = sel_ext ? ext_sync_r[1] : sup_sync_r[1];
   wire cmp_level = det_on & cmp_sel;
   wire cmp_rise  = det_on & cmp_level & ~cmp_prev_r;
   // before settling the analog side is not trusted, so no event
   wire armed     = (state_r == LVDC_READY);
   wire ev_req    = armed & cmp_rise & ~mode_rst;
   wire ev_rdy    = (state_r == LVDC_SETTLE) && (cnt_r == SETTLE_LAST);
   // limitation: a level already below when the wait ends gives no
   // edge and so no request; software sees it in the compare flag,
   // which is why it checks that flag before arming

   // pins towards the analog side follow the control bits directly
   assign detector_enable   = det_on;
   assign ext_input_route   = sel_ext;
   // action mode 1 gives a level towards reset instead of a request
   assign lowvolt_reset_req = armed & cmp_level & mode_rst;

   // ==========================================================
   // axi write path: address and data taken in either order
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_held_r | s_axi_awvalid;
   wire w_have  = w_held_r | s_axi_wvalid;
   wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
   wire [11:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
   wire        wr_ln0  = w_held_r ? w_lane0_r : s_axi_wstrb[0];
   wire        wr_en   = wr_fire & wr_ln0;

   // a pending response blocks both channels, so one write at a time
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

   // write decode; lane 0 off turns the write into a no-op
   wire wr_ctrl   = wr_en && (wr_addr == `LVDC_CTRL_OFS);
   wire wr_ien    = wr_en && (wr_addr == `LVDC_IEN_OFS);
   wire wr_iclr   = wr_en && (wr_addr == `LVDC_ICLR_OFS);
   wire wr_mask   = wr_en && (wr_addr == `LVDC_MASK_OFS);
   wire wr_bset   = wr_en && (wr_addr == `LVDC_BITSET_OFS);
   wire wr_bclr   = wr_en && (wr_addr == `LVDC_BITCLR_OFS);

   // known addresses answer okay, every other one slverr
   wire wr_known  = (wr_addr == `LVDC_CTRL_OFS)
                  | (wr_addr == `LVDC_STAT_OFS)
                  | (wr_addr == `LVDC_IEN_OFS)
                  | (wr_addr == `LVDC_ICLR_OFS)
                  | (wr_addr == `LVDC_MASK_OFS)
                  | (wr_addr == `LVDC_BITSET_OFS)
                  | (wr_addr == `LVDC_BITCLR_OFS);

   // single-bit set/clear forms touch only the named bits
   // only on, select and mode are writable; bit 0 is the live flag
   wire [7:0] ctrl_wmask = (8'h01 << `LVDC_ON_BIT)
                         | (8'h01 << `LVDC_SEL_BIT)
                         | (8'h01 << `LVDC_MODE_BIT);
   wire [7:0] ctrl_nxt   = wr_ctrl ? (wr_data[7:0] & ctrl_wmask)
                         : wr_bset ? (ctrl_r | (wr_data[7:0] & ctrl_wmask))
                         : wr_bclr ? (ctrl_r & ~(wr_data[7:0] & ctrl_wmask))
                         : ctrl_r;

   // status events: request in bit 0, settle done in bit 1
   wire [`LVDC_ST_W-1:0] ev_vec  = {ev_rdy, ev_req};
   // a new event beats a clear in the same cycle
   wire [`LVDC_ST_W-1:0] clr_vec = wr_iclr ? wr_data[`LVDC_ST_W-1:0]
                                           : {`LVDC_ST_W{1'b0}};
   wire [`LVDC_ST_W-1:0] stat_nxt = (stat_r & ~clr_vec) | ev_vec;

   // ==========================================================
   // write channel holding registers and response
   // the response rises the cycle after both parts are present
   // a write with lane 0 off to a known address still answers okay, changing nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r    <= 1'b0;
         aw_addr_r    <= 12'h000;
         w_held_r     <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_lane0_r    <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (wr_fire) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
         end else begin
            if (aw_take) begin
               aw_held_r <= 1'b1;
               aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
               w_held_r  <= 1'b1;
               w_data_r  <= s_axi_wdata;
               w_lane0_r <= s_axi_wstrb[0];
            end
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // control, mask, status and enable registers
   // the mask leaves reset set, so no request leaks out early
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `LVDC_CTRL_RST;
         mask_r <= `LVDC_MASK_RST;
         ien_r  <= `LVDC_IEN_RST;
         stat_r <= {`LVDC_ST_W{1'b0}};
      end else begin
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
         if (wr_mask)
            mask_r <= wr_data[0];
         if (wr_ien)
            ien_r <= wr_data[`LVDC_ST_W-1:0];
      end
   end

   // ==========================================================
   // settle sequencer: counts the stabilisation wait after enable
   // dropping the on bit restarts the wait from zero next time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= LVDC_OFF;
         cnt_r      <= '0;
         cmp_prev_r <= 1'b0;
      end else begin
         cmp_prev_r <= cmp_level;
         case (state_r)
            LVDC_OFF: begin
               cnt_r <= '0;
               if (det_on)
                  state_r <= LVDC_SETTLE;
            end
            LVDC_SETTLE: begin
               if (!det_on)
                  state_r <= LVDC_OFF;
               else if (cnt_r == SETTLE_LAST)
                  state_r <= LVDC_READY;
               else
                  cnt_r <= cnt_r + CNT_W'(1);
            end
            // the counter rests here until the on bit drops
            LVDC_READY: begin
               if (!det_on)
                  state_r <= LVDC_OFF;
            end
            default: state_r <= LVDC_OFF;
         endcase
      end
   end

   // ==========================================================
   // interrupt: request flag gated by the mask, ready by its enable
   // the request sets whatever the mask says; only the output is gated
   // irq is a level and stays high until the status bit is cleared or its mask or enable gates it off
   assign irq = (stat_r[`LVDC_ST_REQ_BIT] & ~mask_r)
              | (stat_r[`LVDC_ST_RDY_BIT] & ien_r[`LVDC_ST_RDY_BIT]);

   // ==========================================================
   // axi read path, one read outstanding
   wire [7:0] ctrl_rd = {ctrl_r[7:1], cmp_level};
   wire [11:0] rd_a   = s_axi_araddr;
   wire rd_ctrl = (rd_a == `LVDC_CTRL_OFS);
   wire rd_stat = (rd_a == `LVDC_STAT_OFS);
   wire rd_ien  = (rd_a == `LVDC_IEN_OFS);
   wire rd_mask = (rd_a == `LVDC_MASK_OFS);
   wire rd_wo   = (rd_a == `LVDC_ICLR_OFS)
                | (rd_a == `LVDC_BITSET_OFS)
                | (rd_a == `LVDC_BITCLR_OFS);
   wire [31:0] rd_word = rd_ctrl ? {24'h0, ctrl_rd}
                       : rd_stat ? {30'h0, stat_r}
                       : rd_ien  ? {30'h0, ien_r}
                       : rd_mask ? {31'h0, mask_r}
                       : 32'h0000_0000;
   wire rd_ok = rd_ctrl | rd_stat | rd_ien | rd_mask | rd_wo;

   // a read waits while the last answer stands
   assign s_axi_arready = ~s_axi_rvalid;

   // read data is registered with the answer and holds until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // lvdc_core

/* verification/lvdc_core_sva.sv */
// port assertions of the low-voltage detect control block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module lvdc_core_sva
   import lvdc_pkg::*;
#(
   parameter int SETTLE_CYCLES = 8
) (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire lvdc_pkg::lvdc_resp_t s_axi_bresp,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_rvalid,
   input wire logic                 ext_below_level,
   input wire logic                 detector_enable,
   input wire logic                 ext_input_route,
   input wire logic                 lowvolt_reset_req,
   input wire logic                 irq
);
   // one cycle of grace after reset, so values seen before reset do
   // not count as a change at the first edge after it
   logic rst_done_r;
   int   on_cnt;
   always_ff @(posedge aclk) begin
      rst_done_r <= aresetn;
   end
   // cycles since the detector was switched on, held at the wait length
   always_ff @(posedge aclk) begin
      if (!aresetn || !detector_enable)
         on_cnt <= 0;
      else if (on_cnt < SETTLE_CYCLES)
         on_cnt <= on_cnt + 1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !rst_done_r);
   // ======================================================
   // bus answers
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write got no response");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_busy_refuse: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read got no data");
   // ======================================================
   // detector control
   a_off_quiet: assert property (!detector_enable
      |-> !lowvolt_reset_req)
      else $error("reset request while detector off");
   a_ext_quiet: assert property ((ext_input_route
      && !ext_below_level) [*4] |-> !lowvolt_reset_req)
      else $error("reset request with external input high");
   a_on_by_write: assert property ($changed(detector_enable)
      |-> $rose(s_axi_bvalid))
      else $error("enable moved without a write");
   a_route_by_write: assert property ($changed(ext_input_route)
      |-> $rose(s_axi_bvalid))
      else $error("input select moved without a write");
   a_settle_first: assert property (lowvolt_reset_req
      |-> on_cnt >= SETTLE_CYCLES)
      else $error("reset request before the settle wait ended");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_irq: cover property ($rose(irq));
   c_reset_req: cover property ($rose(lowvolt_reset_req));
endmodule // lvdc_core_sva

/* verification/lvdc_core_tb_top.sv */
// self-checking bench of the low-voltage detect control block
// assumes design, package and checker compiled before this file
`timescale 1ns/10ps
`include "lvdc_consts.svh"
module lvdc_core_tb_top;
   import lvdc_pkg::*;
   localparam int SETTLE = 8; // short settle so the run stays brief
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   lvdc_resp_t s_axi_bresp, s_axi_rresp;
   logic supply_below_level = 1'b0, ext_below_level = 1'b0;
   logic detector_enable, ext_input_route, lowvolt_reset_req, irq;
   int err_count = 0, samples_checked = 0, cycles = 0;
   lvdc_core #(.SETTLE_CYCLES(SETTLE)) dut (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .s_axi_awaddr      (s_axi_awaddr),
      .s_axi_awvalid     (s_axi_awvalid),
      .s_axi_awready     (s_axi_awready),
      .s_axi_wdata       (s_axi_wdata),
      .s_axi_wstrb       (s_axi_wstrb),
      .s_axi_wvalid      (s_axi_wvalid),
      .s_axi_wready      (s_axi_wready),
      .s_axi_bresp       (s_axi_bresp),
      .s_axi_bvalid      (s_axi_bvalid),
      .s_axi_bready      (s_axi_bready),
      .s_axi_araddr      (s_axi_araddr),
      .s_axi_arvalid     (s_axi_arvalid),
      .s_axi_arready     (s_axi_arready),
      .s_axi_rdata       (s_axi_rdata),
      .s_axi_rresp       (s_axi_rresp),
      .s_axi_rvalid      (s_axi_rvalid),
      .s_axi_rready      (s_axi_rready),
      .supply_below_level(supply_below_level),
      .ext_below_level   (ext_below_level),
      .detector_enable   (detector_enable),
      .ext_input_route   (ext_input_route),
      .lowvolt_reset_req (lowvolt_reset_req),
      .irq               (irq)
   );
   initial forever #5 aclk = ~aclk;
   // hang guard: whole run needs about 150 cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ======================================================
   // shared tasks
   task automatic report_and_stop();
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input lvdc_resp_t er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // waits for the response; only the hang guard ends it if none comes
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [11:0] a, input lvdc_resp_t er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd_v = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, er);
   endtask
   task automatic rv(input logic [11:0] a, input logic [31:0] e);
      rd(a, 2'h0);
      chk(rd_v, e);
   endtask
   // ======================================================
   // scenarios
   task automatic t_reset();
      rv(`LVDC_CTRL_OFS, 32'h0);
      rv(`LVDC_MASK_OFS, 32'h1);
      rv(`LVDC_STAT_OFS, 32'h0);
      chk(detector_enable, 1'b0);
   endtask
   task automatic t_arm();
      wr(`LVDC_MASK_OFS, 32'h1, 2'h0);
      wr(`LVDC_CTRL_OFS, 32'h84, 2'h0);
      tick(1);
      chk(ext_input_route, 1'b1);
      chk(detector_enable, 1'b1);
      tick(SETTLE + 2);
      rv(`LVDC_STAT_OFS, 32'h2);
      rv(`LVDC_CTRL_OFS, 32'h84);
      ext_below_level <= 1'b1;
      tick(4);
      rv(`LVDC_CTRL_OFS, 32'h85);
      rv(`LVDC_STAT_OFS, 32'h3);
      chk(irq, 1'b0);
      wr(`LVDC_ICLR_OFS, 32'h1, 2'h0);
      rv(`LVDC_STAT_OFS, 32'h2);
      wr(`LVDC_MASK_OFS, 32'h0, 2'h0);
      tick(1);
      chk(irq, 1'b0);
      ext_below_level <= 1'b0;
      tick(4);
      ext_below_level <= 1'b1;
      tick(4);
      chk(irq, 1'b1);
      wr(`LVDC_ICLR_OFS, 32'h1, 2'h0);
      tick(1);
      chk(irq, 1'b0);
   endtask
   task automatic t_ien();
      wr(`LVDC_IEN_OFS, 32'h2, 2'h0);
      tick(1);
      chk(irq, 1'b1);
      wr(`LVDC_IEN_OFS, 32'h0, 2'h0);
      tick(1);
      chk(irq, 1'b0);
   endtask
   task automatic t_stop();
      wr(`LVDC_BITCLR_OFS, 32'h80, 2'h0);
      tick(1);
      chk(detector_enable, 1'b0);
      chk(ext_input_route, 1'b1);
      rv(`LVDC_CTRL_OFS, 32'h04);
      ext_below_level <= 1'b0;
      tick(4);
      ext_below_level <= 1'b1;
      tick(4);
      chk(irq, 1'b0);
   endtask
   task automatic t_mode();
      wr(`LVDC_BITSET_OFS, 32'h82, 2'h0);
      tick(SETTLE + 4);
      chk(lowvolt_reset_req, 1'b1);
      rv(`LVDC_STAT_OFS, 32'h2);
      wr(`LVDC_BITCLR_OFS, 32'h04, 2'h0);
      tick(4);
      chk(lowvolt_reset_req, 1'b0);
      supply_below_level <= 1'b1;
      tick(4);
      chk(lowvolt_reset_req, 1'b1);
   endtask
   task automatic t_bad();
      // lane 0 off: the write answers okay and changes nothing
      s_axi_wstrb <= 4'h0;
      wr(`LVDC_CTRL_OFS, 32'h0, 2'h0);
      s_axi_wstrb <= 4'hf;
      rv(`LVDC_CTRL_OFS, 32'h83);
      rv(`LVDC_ICLR_OFS, 32'h0);
      wr(12'h020, 32'h1, 2'h2);
      rd(12'h020, 2'h2);
      chk(rd_v, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_arm();
      t_ien();
      t_stop();
      t_mode();
      t_bad();
      aresetn <= 1'b0;
      tick(3);
      aresetn <= 1'b1;
      t_reset();
      report_and_stop();
   end
endmodule // lvdc_core_tb_top
bind lvdc_core lvdc_core_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
   .aclk             (aclk),
   .aresetn          (aresetn),
   .s_axi_awvalid    (s_axi_awvalid),
   .s_axi_awready    (s_axi_awready),
   .s_axi_wvalid     (s_axi_wvalid),
   .s_axi_wready     (s_axi_wready),
   .s_axi_bresp      (s_axi_bresp),
   .s_axi_bvalid     (s_axi_bvalid),
   .s_axi_bready     (s_axi_bready),
   .s_axi_arvalid    (s_axi_arvalid),
   .s_axi_arready    (s_axi_arready),
   .s_axi_rvalid     (s_axi_rvalid),
   .ext_below_level  (ext_below_level),
   .detector_enable  (detector_enable),
   .ext_input_route  (ext_input_route),
   .lowvolt_reset_req(lowvolt_reset_req),
   .irq              (irq)
);
